// ---- rmp_defines.vh ----
/*
  Constants for the region memory protection block: register addresses,
  field positions, reset values and access permission codes.
  Assumes it is included by bare name from the design file.
*/
`ifndef RMP_DEFINES_VH
`define RMP_DEFINES_VH

// Register addresses on the core's private register port.
`define RMP_ADDR_TYPE     32'he000ed90
`define RMP_ADDR_CTRL     32'he000ed94
`define RMP_ADDR_RSEL     32'he000ed98
`define RMP_ADDR_RBASE    32'he000ed9c
`define RMP_ADDR_RATTR    32'he000eda0

// Control register fields.
`define RMP_CTRL_ENABLE   0
`define RMP_CTRL_FHPE     1
`define RMP_CTRL_PRIVBG   2
`define RMP_CTRL_RESET    3'h0

// Region base register fields.
`define RMP_BASE_LSB      5
`define RMP_BASE_VALID    4
`define RMP_BASE_REG_MSB  3

// Attribute and size register fields.
`define RMP_ATTR_XN       28
`define RMP_ATTR_AP_MSB   26
`define RMP_ATTR_AP_LSB   24
`define RMP_ATTR_TEX_MSB  21
`define RMP_ATTR_TEX_LSB  19
`define RMP_ATTR_S        18
`define RMP_ATTR_C        17
`define RMP_ATTR_B        16
`define RMP_ATTR_SRD_MSB  15
`define RMP_ATTR_SRD_LSB  8
`define RMP_ATTR_SZ_MSB   5
`define RMP_ATTR_SZ_LSB   1
`define RMP_ATTR_EN       0
`define RMP_ATTR_WMASK    32'h173fff3f
`define RMP_ATTR_RESET    32'h00000000

// Size codes: smallest legal size, and smallest size with subregions.
`define RMP_SIZE_MIN      5'h04
`define RMP_SIZE_SUBMIN   5'h07

// Access permission codes.
`define RMP_AP_NONE       3'h0
`define RMP_AP_PRW        3'h1
`define RMP_AP_PRW_URO    3'h2
`define RMP_AP_FULL       3'h3
`define RMP_AP_RSVD       3'h4
`define RMP_AP_PRO        3'h5
`define RMP_AP_RO         3'h6
`define RMP_AP_RO2        3'h7

// System control space window.
`define RMP_SCS_BASE      20'he000e

`endif

// ---- rmp_region_protect.v ----
/*
  Region memory protection unit: control, region select, region base and
  region attribute registers, plus a combinational permit-or-fault check
  of every fetch and load/store access against all regions in parallel.
  Assumes the core drives the register port and the access port
  synchronously to clock, and flags handler priority -1/-2 itself.
*/
`timescale 1ns/1ps
`include "rmp_defines.vh"

module rmp_region_protect
#(
  parameter NREG = 8,                   // Number of regions, 8 or 16.
  parameter RIW  = 3                    // Region index width, log2 NREG.
)
(
  input  wire        clock,             // Core clock, 25 MHz.
  input  wire        nrst,              // Asynchronous reset, active low.
  input  wire        reg_write,         // Register write strobe.
  input  wire        reg_read,          // Register read strobe.
  input  wire [31:0] reg_addr,          // Register byte address.
  input  wire [31:0] reg_wdata,         // Register write data.
  output reg  [31:0] reg_rdata,         // Register read data, next cycle.
  input  wire        acc_valid,         // Access request this cycle.
  input  wire [31:0] acc_addr,          // Access byte address.
  input  wire        acc_priv,          // Access is privileged.
  input  wire        acc_write,         // Access is a data write.
  input  wire        acc_fetch,         // Access is an instruction fetch.
  input  wire        acc_vector,        // Access is a vector table read.
  input  wire        acc_neg_prio,      // Executing at priority -1 or -2.
  output wire        acc_permit,        // Access allowed.
  output wire        acc_fault,         // Memory management fault.
  output wire        acc_default_map,   // Default map attributes apply.
  output wire        acc_strong_order,  // Strongly ordered treatment.
  output wire        acc_xn,            // Execute-never in force.
  output wire        acc_region_hit,    // A region supplied attributes.
  output wire [3:0]  acc_region,        // Winning region number.
  output wire [2:0]  acc_tex,           // Type extension of winner.
  output wire        acc_shareable,     // Shareable bit of winner.
  output wire        acc_cacheable,     // C bit of winner.
  output wire        acc_bufferable,    // B bit of winner.
  output wire        ctrl_enable,       // Global protection enable.
  output wire        ctrl_fhpe,         // Handler protect enable.
  output wire        ctrl_privbg        // Privileged background enable.
);

  // Control, region select, base and attribute registers.
  reg  [2:0]  protection_control_reg;  // Enable, handler, background.
  reg  [7:0]  region_select_reg;       // Currently selected region.
  reg  [26:0] base_mem [0:NREG-1];     // Base bits 31..5 per region.
  reg  [31:0] attr_mem [0:NREG-1];     // Attribute and size per region.

  // Decoded register strobes.
  wire        wr_ctrl;                 // Write to control register.
  wire        wr_rsel;                 // Write to region select.
  wire        wr_base;                 // Write to region base.
  wire        wr_attr;                 // Write to attribute register.
  wire        base_valid;              // Base write carries a region.
  wire [7:0]  base_target;             // Region a base write lands in.
  wire        sel_ok;                  // Selected region exists.
  wire [RIW-1:0] sel_idx;              // Selected region as index.

  // Per-region match results.
  wire [NREG-1:0] hit;                 // Region covers the address.

  // Winner of the priority search.
  reg         win_hit;                 // Any enabled region matched.
  reg  [3:0]  win_idx;                 // Highest matching region.
  reg  [31:0] win_attr;                // Attributes of the winner.

  // Access decision terms.
  reg         perm_ok;                 // Permission field allows it.
  wire [2:0]  win_ap;                  // Permission field of winner.
  wire        in_scs;                  // Address in system control space.
  wire        bypass;                  // Checking is switched off.
  wire        bg_use;                  // Background region applies.
  wire        region_ok;               // Winning region allows access.
  wire        allow;                   // Final permit decision.

  assign ctrl_enable = protection_control_reg[`RMP_CTRL_ENABLE];
  assign ctrl_fhpe   = protection_control_reg[`RMP_CTRL_FHPE];
  assign ctrl_privbg = protection_control_reg[`RMP_CTRL_PRIVBG];

  // Address decode of the register port.
  assign wr_ctrl = reg_write && (reg_addr == `RMP_ADDR_CTRL);
  assign wr_rsel = reg_write && (reg_addr == `RMP_ADDR_RSEL);
  assign wr_base = reg_write && (reg_addr == `RMP_ADDR_RBASE);
  assign wr_attr = reg_write && (reg_addr == `RMP_ADDR_RATTR);

  // A base write with the valid bit retargets the select.
  assign base_valid  = reg_wdata[`RMP_BASE_VALID];
  assign base_target = base_valid ?
                       {4'h0, reg_wdata[`RMP_BASE_REG_MSB:0]} :
                       region_select_reg;
  // A select past the last region turns attribute writes and base writes without the valid bit into no-ops.
  assign sel_ok  = (region_select_reg < NREG);
  assign sel_idx = region_select_reg[RIW-1:0];

  // Control and region select registers.
  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      protection_control_reg <= `RMP_CTRL_RESET;
      region_select_reg      <= 8'h00;
    end
    else
    begin
      // Control layout: bit 0 enable, 1 handler, 2 background.
      if (wr_ctrl)
      begin
        protection_control_reg <= reg_wdata[2:0];
      end
      // Full eight-bit region number is kept.
      if (wr_rsel)
      begin
        region_select_reg <= reg_wdata[7:0];
      end
      else if (wr_base && base_valid)
      begin
        region_select_reg <= {4'h0, reg_wdata[`RMP_BASE_REG_MSB:0]};
      end
    end
  end

  // Per-region storage and address matching, one copy per region.
  genvar gi;
  generate
    for (gi = 0; gi < NREG; gi = gi + 1)
    begin : g_reg
      wire [4:0]  sz_raw;              // Programmed size code.
      wire [4:0]  sz;                  // Size clamped to the minimum.
      wire [32:0] mask;                // Ones above the region size.
      wire [31:0] base_full;           // Base as a byte address.
      wire        addr_in;             // Address falls inside region.
      wire [31:0] sub_sh;              // Address shifted to subregion.
      wire [2:0]  sub_idx;             // Subregion number of address.
      wire        sub_off;             // Subregion is disabled.

      // Attribute writes keep only the defined fields.
      always @(posedge clock or negedge nrst)
      begin
        if (!nrst)
        begin
          base_mem[gi] <= 27'h0000000;
          attr_mem[gi] <= `RMP_ATTR_RESET;
        end
        else
        begin
          // Base lands in the region named by the write or select.
          if (wr_base && (base_target == gi))
          begin
            base_mem[gi] <= reg_wdata[31:`RMP_BASE_LSB];
          end
          if (wr_attr && sel_ok && (sel_idx == gi))
          begin
            attr_mem[gi] <= reg_wdata & `RMP_ATTR_WMASK;
          end
        end
      end

      // Region spans two to the power size+1 bytes.
      assign sz_raw = attr_mem[gi][`RMP_ATTR_SZ_MSB:`RMP_ATTR_SZ_LSB];
      assign sz     = (sz_raw < `RMP_SIZE_MIN) ? `RMP_SIZE_MIN : sz_raw;
      // Size 31 leaves the mask empty: the whole map matches.
      // The mask is 33 bits wide so that a shift by 32 stays defined.
      assign mask      = {33{1'b1}} << ({28'h0, sz} + 33'h1);
      assign base_full = {base_mem[gi], 5'h00};
      // Only the bits above the region size are compared.
      assign addr_in   = ((acc_addr & mask[31:0]) ==
                          (base_full & mask[31:0]));
      // Regions of size code 7 and up hold eight equal subregions.
      // A subregion spans two to the power size-2 bytes, an eighth of the region.
      assign sub_sh  = acc_addr >> (sz - 5'h2);
      assign sub_idx = sub_sh[2:0];
      // Small regions have no subregions; their mask is not used.
      assign sub_off = (sz >= `RMP_SIZE_SUBMIN) &&
                       attr_mem[gi][`RMP_ATTR_SRD_LSB + sub_idx];
      // Every region is matched at once, fetch and data alike.
      assign hit[gi] = attr_mem[gi][`RMP_ATTR_EN] && addr_in &&
                       !sub_off;
    end
  endgenerate

  // Priority search: later, higher-numbered regions override earlier.
  // The loop runs upward, so the last hit it sees is the highest number.
  integer k;
  always @*
  begin
    win_hit  = 1'b0;
    win_idx  = 4'h0;
    win_attr = 32'h00000000;
    for (k = 0; k < NREG; k = k + 1)
    begin
      if (hit[k])
      begin
        win_hit  = 1'b1;
        win_idx  = k[3:0];
        win_attr = attr_mem[k];
      end
    end
  end

  assign win_ap = win_attr[`RMP_ATTR_AP_MSB:`RMP_ATTR_AP_LSB];

  // Permission decode by privilege and direction.
  // Fetches count as reads here; execute-never is applied on its own.
  always @*
  begin
    case (win_ap)
      `RMP_AP_NONE:    perm_ok = 1'b0;
      `RMP_AP_PRW:     perm_ok = acc_priv;
      `RMP_AP_PRW_URO: perm_ok = acc_priv || !acc_write;
      `RMP_AP_FULL:    perm_ok = 1'b1;
      `RMP_AP_PRO:     perm_ok = acc_priv && !acc_write;
      `RMP_AP_RO:      perm_ok = !acc_write;
      `RMP_AP_RO2:     perm_ok = !acc_write;
      // The reserved code is treated as no access.
      default:         perm_ok = 1'b0;
    endcase
  end

  // The system control space occupies one 4 KB window.
  assign in_scs = (acc_addr[31:12] == `RMP_SCS_BASE);

  // Disabled unit, or a -1/-2 handler without handler protection.
  // Handler protection set while disabled has no defined meaning; it stays off.
  assign bypass = !ctrl_enable ||
                  (acc_neg_prio && !ctrl_fhpe);
  // Background only for privileged misses, only while enabled.
  assign bg_use = ctrl_enable && ctrl_privbg && acc_priv &&
                  !win_hit;
  // A fetch from an execute-never region is refused.
  assign region_ok = win_hit && perm_ok &&
                     !(acc_fetch && win_attr[`RMP_ATTR_XN]);
  // Control space and vector reads pass; a miss without background faults.
  assign allow = (in_scs && !acc_fetch) || acc_vector || bypass ||
                 region_ok || bg_use;

  // One decision per access, in the request cycle.
  // Attribute outputs follow the winner even in bypass; qualify with acc_region_hit.
  assign acc_permit      = acc_valid && allow;
  assign acc_fault       = acc_valid && !allow;
  assign acc_default_map = bypass || in_scs || acc_vector ||
                           (!win_hit && bg_use);
  // Control space is always strongly ordered and never executable.
  assign acc_strong_order = in_scs;
  assign acc_xn          = in_scs ||
                           (!bypass && win_hit && win_attr[`RMP_ATTR_XN]);
  assign acc_region_hit  = !bypass && win_hit;
  assign acc_region      = win_idx;
  assign acc_tex         = win_attr[`RMP_ATTR_TEX_MSB:`RMP_ATTR_TEX_LSB];
  assign acc_shareable   = win_attr[`RMP_ATTR_S];
  assign acc_cacheable   = win_attr[`RMP_ATTR_C];
  assign acc_bufferable  = win_attr[`RMP_ATTR_B];

  // Register read data, captured on the read strobe.
  // The word then holds until the next read strobe, so it may be sampled late.
  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      reg_rdata <= 32'h00000000;
    end
    else if (reg_read)
    begin
      case (reg_addr)
        // Type register reports the region count, unified map.
        `RMP_ADDR_TYPE:
        begin
          reg_rdata <= {16'h0000, NREG[7:0], 8'h00};
        end
        `RMP_ADDR_CTRL:
        begin
          reg_rdata <= {29'h0, protection_control_reg};
        end
        `RMP_ADDR_RSEL:
        begin
          reg_rdata <= {24'h0, region_select_reg};
        end
        // Valid bit reads zero; region field shows the select.
        `RMP_ADDR_RBASE:
        begin
          if (sel_ok)
          begin
            reg_rdata <= {base_mem[sel_idx], 1'b0,
                          region_select_reg[3:0]};
          end
          else
          begin
            reg_rdata <= {28'h0, region_select_reg[3:0]};
          end
        end
        `RMP_ADDR_RATTR:
        begin
          if (sel_ok)
          begin
            reg_rdata <= attr_mem[sel_idx];
          end
          else
          begin
            reg_rdata <= 32'h00000000;
          end
        end
        // Unmapped addresses read as zero.
        default:
        begin
          reg_rdata <= 32'h00000000;
        end
      endcase
    end
  end

endmodule

// ---- rmp_checker.sv ----
/*
  Concurrent checks on the protection unit's ports.
  Assumes the defines header and a bind onto the top module.
*/
`timescale 1ns/1ps
`include "rmp_defines.vh"
module rmp_checker
(
  input wire        clock,            // Core clock.
  input wire        nrst,             // Reset, active low.
  input wire        reg_write,        // Write strobe.
  input wire        reg_read,         // Read strobe.
  input wire [31:0] reg_addr,         // Register address.
  input wire [31:0] reg_wdata,        // Write data.
  input wire [31:0] reg_rdata,        // Read data.
  input wire        acc_valid,        // Access request.
  input wire [31:0] acc_addr,         // Access address.
  input wire        acc_priv,         // Privileged access.
  input wire        acc_fetch,        // Instruction fetch.
  input wire        acc_vector,       // Vector read.
  input wire        acc_neg_prio,     // Priority -1 or -2.
  input wire        acc_permit,       // Access allowed.
  input wire        acc_fault,        // Access faulted.
  input wire        acc_default_map,  // Default map used.
  input wire        acc_strong_order, // Strongly ordered.
  input wire        acc_xn,           // Execute-never.
  input wire        acc_region_hit,   // Region matched.
  input wire        ctrl_enable,      // Global enable.
  input wire        ctrl_fhpe,        // Handler protect enable.
  input wire        ctrl_privbg       // Background enable.
);
  // Address lies in the system control space.
  wire       scs = acc_addr[31:12] == `RMP_SCS_BASE;
  // Handler priority bypasses region checks while handler protection is off.
  wire       byp = acc_neg_prio && !ctrl_fhpe;
  // Low control bits of the write data.
  wire [2:0] wd3 = reg_wdata[2:0];
  default clocking dc @(posedge clock); endclocking
  default disable iff (!nrst);
  // A control write and a base read, each one step of a longer exchange.
  sequence ctrl_wr; reg_write && reg_addr == `RMP_ADDR_CTRL; endsequence
  sequence base_rd; reg_read && reg_addr == `RMP_ADDR_RBASE; endsequence
  chk_ctrl_bits: assert property (ctrl_wr |=>
    {ctrl_privbg, ctrl_fhpe, ctrl_enable} == $past(wd3))
    else $error("control bits differ from written value");
  chk_base_valid: assert property (base_rd |=> !reg_rdata[4])
    else $error("base read shows valid bit set");
  chk_one_answer: assert property (acc_valid |-> acc_permit ^ acc_fault)
    else $error("permit and fault not exclusive");
  chk_off_default: assert property (acc_valid && !ctrl_enable |->
    acc_permit && acc_default_map)
    else $error("disabled unit did not use default map");
  chk_scs_attr: assert property (scs |-> acc_xn && acc_strong_order)
    else $error("control space lacks xn or ordering");
  chk_scs_vector: assert property (acc_valid && ((scs && !acc_fetch) || acc_vector)
    |-> acc_permit)
    else $error("control space or vector access refused");
  chk_prio_bypass: assert property (acc_valid && byp |-> acc_permit)
    else $error("handler bypass did not permit");
  chk_bg_priv: assert property (acc_valid && ctrl_enable && ctrl_privbg && acc_priv
    && !acc_region_hit |-> acc_permit && acc_default_map)
    else $error("privileged miss not on background map");
  chk_miss_fault: assert property (acc_valid && ctrl_enable && !acc_region_hit && !scs
    && !acc_vector && !byp && !(ctrl_privbg && acc_priv) |-> acc_fault)
    else $error("uncovered access did not fault");
endmodule
bind rmp_region_protect rmp_checker i_chk (.clock, .nrst, .reg_write, .reg_read, .reg_addr,
  .reg_wdata, .reg_rdata, .acc_valid, .acc_addr, .acc_priv, .acc_fetch, .acc_vector,
  .acc_neg_prio, .acc_permit, .acc_fault, .acc_default_map, .acc_strong_order, .acc_xn,
  .acc_region_hit, .ctrl_enable, .ctrl_fhpe, .ctrl_privbg);

// ---- rmp_core_model.sv ----
/*
  Core access path model: presents one fetch or load/store request.
  Assumes req is called just after a rising clock edge.
*/
`timescale 1ns/1ps
module rmp_core_model
(
  input  wire        clock,        // Core clock.
  output reg         acc_valid,    // Request present.
  output reg  [31:0] acc_addr,     // Byte address.
  output reg         acc_priv,     // Privileged.
  output reg         acc_write,    // Data write.
  output reg         acc_fetch,    // Instruction fetch.
  output reg         acc_vector,   // Vector read.
  output reg         acc_neg_prio  // Handler at -1 or -2.
);
  // No request at time zero.
  initial {acc_valid, acc_addr, acc_priv, acc_write, acc_fetch, acc_vector, acc_neg_prio} = 0;
  // Drive one request, held until the next call; fetches and data use one path.
  task req(input [31:0] a, input [4:0] k);
  begin
    acc_valid <= 1'b1;
    acc_addr <= a;
    {acc_priv, acc_write, acc_fetch, acc_vector, acc_neg_prio} <= k;
    @(posedge clock);
  end
  endtask
endmodule

// ---- test_region_memory_protection.sv ----
/*
  Self-checking bench for the protection unit.
  Assumes the design, the defines header, the core model and the checker.
*/
`timescale 1ns/1ps
`include "rmp_defines.vh"
module test_region_memory_protection;
  reg         clock;        // Core clock.
  reg         nrst;         // Reset, active low.
  reg         reg_write;    // Write strobe.
  reg         reg_read;     // Read strobe.
  reg  [31:0] reg_addr;     // Register address.
  reg  [31:0] reg_wdata;    // Write data.
  wire [31:0] reg_rdata;    // Read data.
  wire        acc_valid, acc_priv, acc_write, acc_fetch, acc_vector, acc_neg_prio;
  wire [31:0] acc_addr;     // Access address.
  wire        acc_permit, acc_fault, acc_default_map, acc_strong_order, acc_xn;
  wire        acc_region_hit, acc_shareable, acc_cacheable, acc_bufferable;
  wire [3:0]  acc_region;   // Winning region.
  wire [2:0]  acc_tex;      // Winner type field.
  wire        ctrl_enable, ctrl_fhpe, ctrl_privbg;
  integer     mismatches;   // Failed compares.
  integer     checks_done;  // All compares.
  integer     seed;         // Random seed.
  integer     ap;           // Permission code.
  integer     k;            // Access kind.
  reg  [31:0] rv;           // Last read value.
  rmp_region_protect i_dut (.clock, .nrst, .reg_write, .reg_read, .reg_addr, .reg_wdata,
    .reg_rdata, .acc_valid, .acc_addr, .acc_priv, .acc_write, .acc_fetch, .acc_vector,
    .acc_neg_prio, .acc_permit, .acc_fault, .acc_default_map, .acc_strong_order, .acc_xn,
    .acc_region_hit, .acc_region, .acc_tex, .acc_shareable, .acc_cacheable,
    .acc_bufferable, .ctrl_enable, .ctrl_fhpe, .ctrl_privbg);
  rmp_core_model i_core (.clock, .acc_valid, .acc_addr, .acc_priv, .acc_write, .acc_fetch,
    .acc_vector, .acc_neg_prio);
  // Expected permission from code, privilege and direction.
  function exp_ap(input [2:0] c, input p, input w);
  begin
    case (c)
      3'h1: exp_ap = p;
      3'h2: exp_ap = p | !w;
      3'h3: exp_ap = 1'b1;
      3'h5: exp_ap = p & !w;
      3'h6, 3'h7: exp_ap = !w;
      default: exp_ap = 1'b0;
    endcase
  end
  endfunction
  // Compare one word and count it.
  task check(input [31:0] got, input [31:0] exp);
  begin
    checks_done = checks_done + 1;
    if (got !== exp)
    begin
      mismatches = mismatches + 1;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  end
  endtask
  // Compare the permit and fault pair.
  task acc_chk(input e);
    check({30'h0, acc_permit, acc_fault}, {30'h0, e, !e});
  endtask
  // One register write, then an idle cycle.
  task wr(input [31:0] a, input [31:0] d);
  begin
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_write <= 1'b0;
    @(posedge clock);
  end
  endtask
  // One register read; data is taken a cycle later.
  task rd(input [31:0] a);
  begin
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_read <= 1'b0;
    @(posedge clock);
    rv = reg_rdata;
  end
  endtask
  // Issue an access and compare the decision.
  task go(input [31:0] a, input [4:0] kd, input e);
  begin
    i_core.req(a, kd);
    acc_chk(e);
  end
  endtask
  // Print the verdict and stop.
  task tally_and_finish;
  begin
    if (mismatches == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  end
  endtask
  // Free-running clock, 40 ns period.
  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // Hang guard.
  initial
  begin
    repeat (20000) @(posedge clock);
    mismatches = mismatches + 1;
    tally_and_finish;
  end
  // Main sequence.
  initial
  begin
    {nrst, reg_write, reg_read, reg_addr, reg_wdata} = 0;
    mismatches = 0;
    checks_done = 0;
    seed = 32'hf419;
    repeat (10) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    check({29'h0, ctrl_privbg, ctrl_fhpe, ctrl_enable}, 32'h0);
    go(32'h20001000, 5'h08, 1'b1);
    rd(32'he000edc0);
    check(rv, 32'h0);
    rd(`RMP_ADDR_TYPE);
    check(rv, 32'h00000800);
    wr(`RMP_ADDR_RSEL, 32'h000000a7);
    rd(`RMP_ADDR_RSEL);
    check(rv, 32'h000000a7);
    wr(`RMP_ADDR_RSEL, 32'h7);
    wr(`RMP_ADDR_RATTR, 32'hffffffff);
    rd(`RMP_ADDR_RATTR);
    check(rv, 32'h173fff3f);
    wr(`RMP_ADDR_RATTR, 32'h0);
    wr(`RMP_ADDR_RBASE, 32'h20000012);
    rd(`RMP_ADDR_RSEL);
    check(rv, 32'h2);
    wr(`RMP_ADDR_RATTR, 32'h0000001b);
    wr(`RMP_ADDR_RBASE, 32'h30000013);
    wr(`RMP_ADDR_RATTR, 32'h03000009);
    wr(`RMP_ADDR_RBASE, 32'h20000015);
    wr(`RMP_ADDR_RATTR, 32'h130f0213);
    wr(`RMP_ADDR_RBASE, 32'h2000040a);
    rd(`RMP_ADDR_RBASE);
    check(rv, 32'h20000405);
    wr(`RMP_ADDR_RBASE, 32'h20000000);
    wr(`RMP_ADDR_CTRL, 32'h1);
    go(32'h20000100, 5'h00, 1'b1);
    check({21'h0, acc_tex, acc_shareable, acc_cacheable, acc_bufferable,
      acc_region_hit, acc_region}, 32'h000001f5);
    go(32'h20000100, 5'h14, 1'b0);
    go(32'h20000090, 5'h00, 1'b0);
    check({28'h0, acc_region}, 32'h2);
    go(32'h3000001f, 5'h00, 1'b1);
    go(32'h30000020, 5'h10, 1'b0);
    go(32'he000ed00, 5'h08, 1'b1);
    check({30'h0, acc_xn, acc_strong_order}, 32'h3);
    go(32'he000e010, 5'h14, 1'b0);
    go(32'h00000004, 5'h02, 1'b1);
    go(32'h40000000, 5'h01, 1'b1);
    wr(`RMP_ADDR_CTRL, 32'h5);
    go(32'h40000000, 5'h10, 1'b1);
    check({31'h0, acc_default_map}, 32'h1);
    go(32'h40000000, 5'h00, 1'b0);
    go(32'h20001000, 5'h10, 1'b0);
    wr(`RMP_ADDR_CTRL, 32'h7);
    go(32'h40000000, 5'h01, 1'b0);
    for (ap = 0; ap < 8; ap = ap + 1)
    begin
      wr(`RMP_ADDR_RATTR, 32'h10080213 | (ap << 24));
      for (k = 0; k < 4; k = k + 1)
        go(32'h20000000 + ($random(seed) & 32'h7c), {k[1], k[0], 3'h0},
          exp_ap(ap, k[1], k[0]));
    end
    wr(`RMP_ADDR_RSEL, 32'h0);
    wr(`RMP_ADDR_RATTR, 32'h0300003f);
    go(32'h40000000, 5'h08, 1'b1);
    wr(`RMP_ADDR_CTRL, 32'h4);
    go(32'h20001000, 5'h00, 1'b1);
    go(32'he000e010, 5'h10, 1'b1);
    check({30'h0, acc_xn, acc_strong_order}, 32'h3);
    tally_and_finish;
  end
endmodule
